// ==== cbi_pkg.sv ====
// Constants and types shared by the processor memory bus interface
//==========================================================================
// How it works
// - Unsegmented mode drives a 16-bit byte address on the shared bus.
// - Segmented mode adds a seven-bit segment number: 23-bit address total.
// - Segment number is valid one cycle before the strobe and throughout.
// - Fetches are words, operands bytes or words; words use even addresses.
// - Word transfers move all sixteen bits through both banks together.
// - Byte reads take the upper half when the low bit is zero.
// - Byte writes copy the byte onto both halves; memory picks one bank.
// - Strobe low starts a cycle; status is valid before its rise.
// - Reads release the bus, then data strobe low lets memory drive.
// - Writes put data first, strobe after setup, hold past the rise.
//==========================================================================
package cbi_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Bus timing figures in nanoseconds
    localparam int T_ADDR_SETUP_NS = 55;
    localparam int T_DSTB_SETUP_NS = 55;
    localparam int T_DSTB_LOW_NS   = 160;
    localparam int T_DSTB_HOLD_NS  = 80;

    localparam int CNT_W = 8;

    // Least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] ASTB_LOW_CYC =
        CNT_W'((T_ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] DSTB_SETUP_CYC =
        CNT_W'((T_DSTB_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] DSTB_LOW_CYC =
        CNT_W'((T_DSTB_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] DSTB_HOLD_CYC =
        CNT_W'((T_DSTB_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    localparam int ADDR_W = 16;
    localparam int SEG_W  = 7;
    localparam int STAT_W = 4;

    // Cycle status shown between transactions (internal operation)
    localparam logic [STAT_W-1:0] STATUS_IDLE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 16'h0000;
    localparam logic [SEG_W-1:0]  SEG_RESET   = 7'h00;

    // Gray codes along IDLE-SETUP-ASLOW-ASHIGH-DSLOW-HOLD
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_ASLOW  = 3'h3,
        ST_ASHIGH = 3'h2,
        ST_DSLOW  = 3'h6,
        ST_HOLD   = 3'h7
    } cbi_state_t;

endpackage : cbi_pkg

// ==== cbi_lane_if.sv ====
// Byte lane steering signals between the sequencer and the lane unit
`timescale 1ns/1ps
interface cbi_lane_if;
    logic        byte_op;
    logic        addr_lsb;
    logic [15:0] wdata;
    logic [15:0] bus_rdata;
    logic [15:0] bus_wdata;
    logic [15:0] rdata;

    modport seq  (output byte_op, addr_lsb, wdata, bus_rdata,
                  input  bus_wdata, rdata);
    modport lane (input  byte_op, addr_lsb, wdata, bus_rdata,
                  output bus_wdata, rdata);
endinterface : cbi_lane_if

// ==== cbi_lane.sv ====
// Byte duplication on writes and byte selection on reads
`timescale 1ns/1ps
module cbi_lane
(
    cbi_lane_if.lane lanes
);

    //======================================================================
    // Write lanes
    //======================================================================
    always_comb
    begin
        if (lanes.byte_op)
            lanes.bus_wdata = {lanes.wdata[7:0], lanes.wdata[7:0]};
        else
            lanes.bus_wdata = lanes.wdata;
    end

    //======================================================================
    // Read lanes: even byte lives on the upper half
    //======================================================================
    always_comb
    begin
        if (!lanes.byte_op)
            lanes.rdata = lanes.bus_rdata;
        else if (lanes.addr_lsb)
            lanes.rdata = {8'h00, lanes.bus_rdata[7:0]};
        else
            lanes.rdata = {8'h00, lanes.bus_rdata[15:8]};
    end

endmodule // cbi_lane

// ==== cbi_mem_bus.sv ====
// Processor side sequencer for the multiplexed memory bus
`timescale 1ns/1ps
module cbi_mem_bus
#(
    parameter bit SEGMENTED = 1'b1
)
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    // User request side
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic [15:0] REQ_ADDR,
    input  wire logic [6:0]  REQ_SEG,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_BYTE,
    input  wire logic [3:0]  REQ_STATUS,
    input  wire logic        REQ_NORMAL,
    input  wire logic [15:0] REQ_WDATA,
    output logic             RSP_VALID,
    output logic             RSP_ERR,
    output logic [15:0]      RSP_RDATA,
    // Memory bus pins
    input  wire logic [15:0] MUXED_ADDR_DATA_I,
    output logic [15:0]      MUXED_ADDR_DATA_O,
    output logic             MUXED_ADDR_DATA_OE_N,
    output logic             ADDR_VALID_STROBE_N,
    output logic             DATA_STROBE_N,
    output logic             MEM_REQUEST_N,
    output logic [3:0]       CYCLE_STATUS,
    output logic             NORMAL_NOT_SYSTEM,
    output logic             BYTE_NOT_WORD,
    output logic             RD_NOT_WR,
    output logic [6:0]       SEGMENT_NUMBER,
    input  wire logic        WAIT_N
);

    localparam int CW = cbi_pkg::CNT_W;

    cbi_pkg::cbi_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [15:0]   addr_r, addr_nxt;
    logic [15:0]   wdata_r, wdata_nxt;
    logic          write_r, write_nxt;
    logic          byte_r, byte_nxt;
    logic [15:0]   ad_o_r, ad_o_nxt;
    logic          ad_oe_n_r, ad_oe_n_nxt;
    logic          astb_n_r, astb_n_nxt;
    logic          dstb_n_r, dstb_n_nxt;
    logic          mrq_n_r, mrq_n_nxt;
    logic [3:0]    stat_r, stat_nxt;
    logic          nns_r, nns_nxt;
    logic          bnw_r, bnw_nxt;
    logic          rnw_r, rnw_nxt;
    logic [6:0]    seg_r, seg_nxt;
    logic          ready_r, ready_nxt;
    logic          rsp_v_r, rsp_v_nxt;
    logic          rsp_e_r, rsp_e_nxt;
    logic [15:0]   rdata_r, rdata_nxt;
    logic          wait_s1_r, wait_s2_r, wait_s3_r, wait_lvl_r;
    logic          wait_lvl_nxt;

    cbi_lane_if lanes ();

    assign lanes.byte_op   = byte_r;
    assign lanes.addr_lsb  = addr_r[0];
    assign lanes.wdata     = wdata_r;
    assign lanes.bus_rdata = MUXED_ADDR_DATA_I;

    cbi_lane u_lane
    (
        .lanes (lanes.lane)
    );

    //======================================================================
    // Wait input synchroniser: level taken once stages two and three agree
    //======================================================================
    always_comb
    begin
        wait_lvl_nxt = wait_lvl_r;
        if (wait_s2_r == wait_s3_r)
            wait_lvl_nxt = wait_s3_r;
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wait_s1_r  <= 1'b1;
            wait_s2_r  <= 1'b1;
            wait_s3_r  <= 1'b1;
            wait_lvl_r <= 1'b1;
        end
        else
        begin
            wait_s1_r  <= WAIT_N;
            wait_s2_r  <= wait_s1_r;
            wait_s3_r  <= wait_s2_r;
            wait_lvl_r <= wait_lvl_nxt;
        end
    end

    //======================================================================
    // Transaction sequencer
    //======================================================================
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        write_nxt   = write_r;
        byte_nxt    = byte_r;
        ad_o_nxt    = ad_o_r;
        ad_oe_n_nxt = ad_oe_n_r;
        astb_n_nxt  = astb_n_r;
        dstb_n_nxt  = dstb_n_r;
        mrq_n_nxt   = mrq_n_r;
        stat_nxt    = stat_r;
        nns_nxt     = nns_r;
        bnw_nxt     = bnw_r;
        rnw_nxt     = rnw_r;
        seg_nxt     = seg_r;
        ready_nxt   = ready_r;
        rsp_v_nxt   = 1'b0;
        rsp_e_nxt   = rsp_e_r;
        rdata_nxt   = rdata_r;
        if (cnt_r != '0)
            cnt_nxt = cnt_r - CW'(1);

        case (state_r)
            cbi_pkg::ST_IDLE:
            begin
                if (REQ_VALID && ready_r)
                begin
                    if (!REQ_BYTE && REQ_ADDR[0])
                    begin
                        // Odd word address is never put on the bus
                        rsp_v_nxt = 1'b1;
                        rsp_e_nxt = 1'b1;
                    end
                    else
                    begin
                        ready_nxt   = 1'b0;
                        addr_nxt    = REQ_ADDR;
                        wdata_nxt   = REQ_WDATA;
                        write_nxt   = REQ_WRITE;
                        byte_nxt    = REQ_BYTE;
                        // Status, size and direction lead the strobe
                        stat_nxt    = REQ_STATUS;
                        nns_nxt     = REQ_NORMAL;
                        bnw_nxt     = REQ_BYTE;
                        rnw_nxt     = !REQ_WRITE;
                        seg_nxt     = SEGMENTED ? REQ_SEG
                                                : cbi_pkg::SEG_RESET;
                        ad_o_nxt    = REQ_ADDR;
                        ad_oe_n_nxt = 1'b0;
                        state_nxt   = cbi_pkg::ST_SETUP;
                    end
                end
            end
            cbi_pkg::ST_SETUP:
            begin
                astb_n_nxt = 1'b0;
                mrq_n_nxt  = 1'b0;
                cnt_nxt    = cbi_pkg::ASTB_LOW_CYC - CW'(1);
                state_nxt  = cbi_pkg::ST_ASLOW;
            end
            cbi_pkg::ST_ASLOW:
            begin
                if (cnt_r == '0)
                begin
                    // Address still driven on the rise for latching
                    astb_n_nxt = 1'b1;
                    state_nxt  = cbi_pkg::ST_ASHIGH;
                    // Reads release the bus a cycle before the strobe,
                    // so memory never drives against our address
                    if (write_r)
                        cnt_nxt = cbi_pkg::DSTB_SETUP_CYC;
                    else
                        cnt_nxt = CW'(1);
                end
            end
            cbi_pkg::ST_ASHIGH:
            begin
                if (write_r)
                    ad_o_nxt = lanes.bus_wdata;
                else
                    ad_oe_n_nxt = 1'b1;
                if (cnt_r == '0)
                begin
                    dstb_n_nxt = 1'b0;
                    cnt_nxt    = cbi_pkg::DSTB_LOW_CYC - CW'(1);
                    state_nxt = cbi_pkg::ST_DSLOW;
                end
            end
            cbi_pkg::ST_DSLOW:
            begin
                // Cycle is stretched while the wait level is low
                if (cnt_r == '0 && wait_lvl_r)
                begin
                    dstb_n_nxt = 1'b1;
                    mrq_n_nxt  = 1'b1;
                    if (!write_r)
                        rdata_nxt = lanes.rdata;
                    cnt_nxt   = write_r ? cbi_pkg::DSTB_HOLD_CYC
                                        : CW'(0);
                    state_nxt = cbi_pkg::ST_HOLD;
                end
            end
            cbi_pkg::ST_HOLD:
            begin
                if (cnt_r == '0)
                begin
                    ad_oe_n_nxt = 1'b1;
                    stat_nxt    = cbi_pkg::STATUS_IDLE;
                    rsp_v_nxt   = 1'b1;
                    rsp_e_nxt   = 1'b0;
                    ready_nxt   = 1'b1;
                    state_nxt   = cbi_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = cbi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_r   <= cbi_pkg::ST_IDLE;
            cnt_r     <= '0;
            addr_r    <= cbi_pkg::ADDR_RESET;
            wdata_r   <= 16'h0000;
            write_r   <= 1'b0;
            byte_r    <= 1'b0;
            ad_o_r    <= 16'h0000;
            ad_oe_n_r <= 1'b1;
            astb_n_r  <= 1'b1;
            dstb_n_r  <= 1'b1;
            mrq_n_r   <= 1'b1;
            stat_r    <= cbi_pkg::STATUS_IDLE;
            nns_r     <= 1'b0;
            bnw_r     <= 1'b0;
            rnw_r     <= 1'b1;
            seg_r     <= cbi_pkg::SEG_RESET;
            ready_r   <= 1'b1;
            rsp_v_r   <= 1'b0;
            rsp_e_r   <= 1'b0;
            rdata_r   <= 16'h0000;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            write_r   <= write_nxt;
            byte_r    <= byte_nxt;
            ad_o_r    <= ad_o_nxt;
            ad_oe_n_r <= ad_oe_n_nxt;
            astb_n_r  <= astb_n_nxt;
            dstb_n_r  <= dstb_n_nxt;
            mrq_n_r   <= mrq_n_nxt;
            stat_r    <= stat_nxt;
            nns_r     <= nns_nxt;
            bnw_r     <= bnw_nxt;
            rnw_r     <= rnw_nxt;
            seg_r     <= seg_nxt;
            ready_r   <= ready_nxt;
            rsp_v_r   <= rsp_v_nxt;
            rsp_e_r   <= rsp_e_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    //======================================================================
    // Outputs, all straight from flops
    //======================================================================
    assign REQ_READY            = ready_r;
    assign RSP_VALID            = rsp_v_r;
    assign RSP_ERR              = rsp_e_r;
    assign RSP_RDATA            = rdata_r;
    assign MUXED_ADDR_DATA_O    = ad_o_r;
    assign MUXED_ADDR_DATA_OE_N = ad_oe_n_r;
    assign ADDR_VALID_STROBE_N  = astb_n_r;
    assign DATA_STROBE_N        = dstb_n_r;
    assign MEM_REQUEST_N        = mrq_n_r;
    assign CYCLE_STATUS         = stat_r;
    assign NORMAL_NOT_SYSTEM    = nns_r;
    assign BYTE_NOT_WORD        = bnw_r;
    assign RD_NOT_WR            = rnw_r;
    assign SEGMENT_NUMBER       = seg_r;

endmodule // cbi_mem_bus

// ==== cbi_mem_bus_assertions.sv ====
// Concurrent checks on the processor memory bus sequencer ports
`timescale 1ns/1ps
module cbi_mem_bus_assertions
(
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        REQ_VALID,
    input wire logic        REQ_READY,
    input wire logic [15:0] REQ_ADDR,
    input wire logic        REQ_BYTE,
    input wire logic        RSP_VALID,
    input wire logic        RSP_ERR,
    input wire logic [15:0] MUXED_ADDR_DATA_O,
    input wire logic        MUXED_ADDR_DATA_OE_N,
    input wire logic        ADDR_VALID_STROBE_N,
    input wire logic        DATA_STROBE_N,
    input wire logic        MEM_REQUEST_N,
    input wire logic [3:0]  CYCLE_STATUS,
    input wire logic        BYTE_NOT_WORD,
    input wire logic        RD_NOT_WR,
    input wire logic [6:0]  SEGMENT_NUMBER
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    logic [7:0] dstb_low_r;
    logic [7:0] dstb_low_nxt;
    logic       take;
    logic       odd_word;

    assign take     = REQ_VALID && REQ_READY;
    assign odd_word = !REQ_BYTE && REQ_ADDR[0];

    // Saturating, so a strobe stuck low cannot wrap and look short
    always_comb
        dstb_low_nxt = DATA_STROBE_N ? 8'h00
                     : dstb_low_r + {7'h00, dstb_low_r != 8'hff};
    always_ff @(posedge CLK or negedge NRST)
        if (!NRST)
            dstb_low_r <= 8'h00;
        else
            dstb_low_r <= dstb_low_nxt;

    //======================================================================
    // Sequences and properties
    sequence astb_low14;
        (!ADDR_VALID_STROBE_N)[*8] ##1 (!ADDR_VALID_STROBE_N)[*6]
            ##1 ADDR_VALID_STROBE_N;
    endsequence
    sequence wr_hold19;
        (!MUXED_ADDR_DATA_OE_N && $stable(MUXED_ADDR_DATA_O))[*8]
            ##1 (!MUXED_ADDR_DATA_OE_N && $stable(MUXED_ADDR_DATA_O))[*8]
            ##1 (!MUXED_ADDR_DATA_OE_N && $stable(MUXED_ADDR_DATA_O))[*3];
    endsequence

    addr_on_bus_a: assert property (take && !odd_word |-> ##2
        (MUXED_ADDR_DATA_O == $past(REQ_ADDR, 2) && !MUXED_ADDR_DATA_OE_N
         && !ADDR_VALID_STROBE_N)) else $error("address not on bus");
    odd_refuse_a: assert property (take && odd_word |-> ##[1:2]
        (RSP_VALID && RSP_ERR && ADDR_VALID_STROBE_N))
        else $error("odd word not refused");
    astb_width_a: assert property ($fell(ADDR_VALID_STROBE_N) |->
        astb_low14) else $error("address strobe width wrong");
    seg_early_a: assert property ($fell(ADDR_VALID_STROBE_N) |->
        $stable(SEGMENT_NUMBER) && $stable(CYCLE_STATUS))
        else $error("segment or status late");
    status_hold_a: assert property (!MEM_REQUEST_N &&
        !$past(MEM_REQUEST_N) |-> $stable(CYCLE_STATUS)
        && $stable(RD_NOT_WR) && $stable(BYTE_NOT_WORD))
        else $error("status changed in cycle");
    read_turn_a: assert property ($fell(DATA_STROBE_N) && RD_NOT_WR |->
        MUXED_ADDR_DATA_OE_N && $past(MUXED_ADDR_DATA_OE_N))
        else $error("bus not released before read strobe");
    wr_setup_a: assert property ($fell(DATA_STROBE_N) && !RD_NOT_WR |->
        !MUXED_ADDR_DATA_OE_N
        && MUXED_ADDR_DATA_O == $past(MUXED_ADDR_DATA_O, 13))
        else $error("write data setup short");
    dstb_width_a: assert property ($rose(DATA_STROBE_N) |->
        dstb_low_r >= 8'h28) else $error("data strobe too short");
    wr_hold_a: assert property ($rose(DATA_STROBE_N) && !RD_NOT_WR |->
        wr_hold19) else $error("write data hold short");
    byte_dup_a: assert property (!RD_NOT_WR && BYTE_NOT_WORD &&
        !DATA_STROBE_N |-> MUXED_ADDR_DATA_O[15:8] == MUXED_ADDR_DATA_O[7:0])
        else $error("byte not duplicated");
endmodule // cbi_mem_bus_assertions

bind cbi_mem_bus cbi_mem_bus_assertions chk
(
    .CLK(CLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_ADDR(REQ_ADDR), .REQ_BYTE(REQ_BYTE), .RSP_VALID(RSP_VALID),
    .RSP_ERR(RSP_ERR), .MUXED_ADDR_DATA_O(MUXED_ADDR_DATA_O),
    .MUXED_ADDR_DATA_OE_N(MUXED_ADDR_DATA_OE_N),
    .ADDR_VALID_STROBE_N(ADDR_VALID_STROBE_N),
    .DATA_STROBE_N(DATA_STROBE_N), .MEM_REQUEST_N(MEM_REQUEST_N),
    .CYCLE_STATUS(CYCLE_STATUS), .BYTE_NOT_WORD(BYTE_NOT_WORD),
    .RD_NOT_WR(RD_NOT_WR), .SEGMENT_NUMBER(SEGMENT_NUMBER)
);

// ==== cbi_mem_model.sv ====
// Byte-banked memory array model on the far side of the bus
`timescale 1ns/1ps
module cbi_mem_model
(
    input  wire logic        clk,
    input  wire logic [15:0] ad_o,
    input  wire logic        ad_oe_n,
    input  wire logic        astb_n,
    input  wire logic        dstb_n,
    input  wire logic        mrq_n,
    input  wire logic        byte_n_word,
    input  wire logic        rd_n_wr,
    input  wire logic [7:0]  wait_len,
    output logic [15:0]      bus,
    output logic             wait_n
);
    logic [15:0] mem [0:255];
    logic [15:0] addr_q   = 16'h0000;
    logic [15:0] last_q   = 16'h0000;
    logic [7:0]  dstb_cnt = 8'h00;
    logic        astb_q   = 1'b1;
    logic        dstb_q   = 1'b1;
    logic        en_odd;
    logic        en_even;

    assign en_odd  = rd_n_wr | ~byte_n_word | addr_q[0];
    assign en_even = rd_n_wr | ~byte_n_word | ~addr_q[0];
    // Undriven bus flips every cycle so a stale value is never trusted
    assign bus = !ad_oe_n ? ad_o
               : (!dstb_n && rd_n_wr && !mrq_n) ? mem[addr_q[8:1]]
               : ~last_q;
    assign wait_n = !(!dstb_n && dstb_cnt >= 8'h1e
                      && dstb_cnt < 8'h1e + wait_len);

    always @(posedge clk)
    begin
        last_q   <= bus;
        astb_q   <= astb_n;
        dstb_q   <= dstb_n;
        dstb_cnt <= dstb_n ? 8'h00 : dstb_cnt + 8'h01;
        if (astb_n && !astb_q)
            addr_q <= bus;
        if (dstb_n && !dstb_q && !rd_n_wr)
        begin
            if (en_even)
                mem[addr_q[8:1]][15:8] <= bus[15:8];
            if (en_odd)
                mem[addr_q[8:1]][7:0] <= bus[7:0];
        end
    end
endmodule // cbi_mem_model

// ==== cpu_memory_bus_interface_tb.sv ====
// Self-checking bench for the processor memory bus sequencer
`timescale 1ns/1ps
module cpu_memory_bus_interface_tb;
    logic        clk = 1'b0;
    logic        nrst;
    logic        req_valid, req_ready, req_write, req_byte, req_normal;
    logic [15:0] req_addr, req_wdata, rsp_rdata, ad_i, ad_o;
    logic [6:0]  req_seg, seg;
    logic [3:0]  req_status, stat;
    logic        rsp_valid, rsp_err, oe_n, astb_n, dstb_n, mrq_n;
    logic        nns, bnw, rnw, wait_n;
    logic [7:0]  wait_len, dstb_run = 8'h00, dstb_w = 8'h00;
    logic [15:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          checks = 0;

    always #2 clk = ~clk;

    cbi_mem_bus uut
    (
        .CLK(clk), .NRST(nrst), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_ADDR(req_addr), .REQ_SEG(req_seg),
        .REQ_WRITE(req_write), .REQ_BYTE(req_byte),
        .REQ_STATUS(req_status), .REQ_NORMAL(req_normal),
        .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err),
        .RSP_RDATA(rsp_rdata), .MUXED_ADDR_DATA_I(ad_i),
        .MUXED_ADDR_DATA_O(ad_o), .MUXED_ADDR_DATA_OE_N(oe_n),
        .ADDR_VALID_STROBE_N(astb_n), .DATA_STROBE_N(dstb_n),
        .MEM_REQUEST_N(mrq_n), .CYCLE_STATUS(stat),
        .NORMAL_NOT_SYSTEM(nns), .BYTE_NOT_WORD(bnw), .RD_NOT_WR(rnw),
        .SEGMENT_NUMBER(seg), .WAIT_N(wait_n)
    );

    cbi_mem_model mem
    (
        .clk(clk), .ad_o(ad_o), .ad_oe_n(oe_n), .astb_n(astb_n),
        .dstb_n(dstb_n), .mrq_n(mrq_n), .byte_n_word(bnw), .rd_n_wr(rnw),
        .wait_len(wait_len), .bus(ad_i), .wait_n(wait_n)
    );

    // Length of the most recent data strobe pulse, in cycles
    always @(posedge clk)
        if (!dstb_n)
            dstb_run <= dstb_run + 8'h01;
        else if (dstb_run != 8'h00)
        begin
            dstb_w   <= dstb_run;
            dstb_run <= 8'h00;
        end

    //======================================================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_req(input logic [15:0] a, input logic [6:0] s,
                          input logic w, input logic b,
                          input logic [3:0] st, input logic n,
                          input logic [15:0] wd);
        int k;
        k = 0;
        @(negedge clk);
        req_valid  = 1'b1;
        req_addr   = a;
        req_seg    = s;
        req_write  = w;
        req_byte   = b;
        req_status = st;
        req_normal = n;
        req_wdata  = wd;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        if (b || !a[0])
            check({req_ready, mrq_n, seg, stat, nns, bnw, rnw},
                  {1'b0, 1'b1, s, st, n, b, !w});
        while (rsp_valid !== 1'b1 && k < 400)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 400)
            check(16'hdead, 16'h0000);
        rd  = rsp_rdata;
        err = rsp_err;
    endtask

    //======================================================================
    // Scenarios
    task automatic t_word();
        do_req(16'hfffe, 7'h7f, 1'b1, 1'b0, 4'h9, 1'b1, 16'h1234);
        check({15'h0000, err}, 16'h0000);
        do_req(16'hfffe, 7'h7f, 1'b0, 1'b0, 4'h9, 1'b1, 16'h0000);
        check(rd, 16'h1234);
        check({8'h00, dstb_w}, 16'h0028);
    endtask

    task automatic t_byte();
        do_req(16'h0020, 7'h01, 1'b1, 1'b1, 4'ha, 1'b0, 16'hc35a);
        do_req(16'h0021, 7'h01, 1'b1, 1'b1, 4'ha, 1'b0, 16'h3ca5);
        do_req(16'h0020, 7'h01, 1'b0, 1'b0, 4'ha, 1'b0, 16'h0000);
        check(rd, 16'h5aa5);
        do_req(16'h0020, 7'h01, 1'b0, 1'b1, 4'ha, 1'b0, 16'h0000);
        check(rd, 16'h005a);
        do_req(16'h0021, 7'h01, 1'b0, 1'b1, 4'ha, 1'b0, 16'h0000);
        check(rd, 16'h00a5);
    endtask

    task automatic t_spaces();
        for (int i = 0; i < 6; i++)
        begin
            do_req(16'h0020, 7'(i), 1'b0, 1'b0, 4'(8 + i), i[0], 16'h0000);
            check(rd, 16'h5aa5);
        end
    endtask

    task automatic t_odd();
        do_req(16'h0033, 7'h02, 1'b0, 1'b0, 4'h9, 1'b0, 16'h0000);
        check({15'h0000, err}, 16'h0001);
        do_req(16'h0021, 7'h02, 1'b1, 1'b0, 4'h9, 1'b0, 16'hffff);
        check({15'h0000, err}, 16'h0001);
        do_req(16'h0020, 7'h02, 1'b0, 1'b0, 4'h9, 1'b0, 16'h0000);
        check(rd, 16'h5aa5);
    endtask

    task automatic t_wait();
        wait_len = 8'h14;
        do_req(16'hfffe, 7'h03, 1'b0, 1'b0, 4'h9, 1'b0, 16'h0000);
        check(rd, 16'h1234);
        check({15'h0000, dstb_w > 8'h28}, 16'h0001);
        wait_len = 8'h00;
    endtask

    //======================================================================
    // Main sequence and watchdog
    initial
    begin
        nrst       = 1'b0;
        req_valid  = 1'b0;
        req_addr   = 16'h0000;
        req_seg    = 7'h00;
        req_write  = 1'b0;
        req_byte   = 1'b0;
        req_status = 4'h0;
        req_normal = 1'b0;
        req_wdata  = 16'h0000;
        wait_len   = 8'h00;
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        // Idle bus and ready handshake straight after reset
        check({4'h0, oe_n, astb_n, dstb_n, mrq_n, rsp_valid, rsp_err,
               req_ready, rnw, stat}, 16'h0f30);
        t_word();
        t_byte();
        t_spaces();
        t_odd();
        t_wait();
        stop_test();
    end

    initial
    begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule // cpu_memory_bus_interface_tb
